// File: core/loop_guard_pkg.sv
package loop_guard_pkg;

  // apb geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [15:0] MODE_IDX = 16'hFF98;
  localparam logic [15:0] RESTART_IDX = 16'hFF99;
  localparam logic [15:0] CAUSE_IDX = 16'hFF9A;
  localparam logic [ADDR_W-1:0] MODE_ADDR = {2'b00, MODE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] RESTART_ADDR = {2'b00, RESTART_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CAUSE_ADDR = {2'b00, CAUSE_IDX, 2'b00};

  // mode register fields and values
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [2:0] MODE_FIXED_TOP = 3'h3;
  localparam int CS_HI_BIT = 4;
  localparam int CS_LO_BIT = 3;
  localparam int PERIOD_MSB = 2;

  // restart register codes
  localparam logic [7:0] RESTART_CODE = 8'hAC;
  localparam logic [7:0] RESTART_READ = 8'h9A;

  // reset cause register field
  localparam int CAUSE_BIT = 4;

  // counter geometry: overflow length is 2^(base + period code)
  localparam int CNT_W = 21;
  localparam logic [4:0] RING_BASE = 5'h0B;
  localparam logic [4:0] XTAL_BASE = 5'h0D;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_ACK
  } bus_phase_t;

  typedef struct packed {
    bus_phase_t phase;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    logic [7:0] mode;
    logic locked;
    logic [CNT_W-1:0] cnt;
    logic wdrst;
    logic cause;
  } guard_state_t;

endpackage

// File: core/loop_guard_timer.sv
`timescale 1ns/1ns
// Contract
// - Counter overflow raises the internal system reset.
// - A watchdog reset sets the cause flag at bit 4 of the cause register.
// - Period code 0..7 gives 2^11..2^18 oscillator or 2^13..2^20 crystal clocks.
// - Source code 00 oscillator, 01 crystal, upper bit set stops counting.
// - Non-stoppable option ignores source writes and always uses the oscillator.
// - After reset, count from the oscillator at period code 111.
// - Mode register resets to 67H.
// - Mode register readable always, writable once; a second write resets unless the stop code is set.
// - Every mode register write inserts one wait cycle on the bus.
// - Non-stoppable option: no stop, only the period changes, once.
// - Stoppable option: source and period change once; stop code halts it.
// - Crystal source pauses while crystal stopped, in halt/stop, or settling.
// - Oscillator source pauses in halt/stop, or oscillator off while on crystal, except in the non-stoppable option.
// - Writing ACH to restart clears the counter; software must do so in time.
// - Any other restart write, or partial write, resets at once unless the stop code is set.
// - Restart register always reads 9AH.
// - Writing the mode register clears the counter; a second write while the stop code is set leaves it unchanged.
module loop_guard_timer
  import loop_guard_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [loop_guard_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [loop_guard_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic PREADY_O,
  output logic [loop_guard_pkg::DATA_W-1:0] PRDATA_O,
  output logic PSLVERR_O,
  // option strap and clock status
  input wire logic OPT_NO_STOP_I,
  input wire logic RING_TICK_I,
  input wire logic XTAL_TICK_I,
  input wire logic XTAL_RUN_I,
  input wire logic HALT_I,
  input wire logic STOP_I,
  input wire logic OSC_SETTLE_I,
  input wire logic CPU_ON_XTAL_I,
  input wire logic RING_OFF_I,
  // reset outputs
  output logic WD_RESET_O,
  output logic WD_CAUSE_O
);
  import loop_guard_pkg::*;

  guard_state_t q, d;
  logic access;
  logic hit_mode, hit_rst, hit_cause;
  logic stopped, use_xtal, tick, ovf, fire;
  logic eff_mode, eff_rst, good_rst;
  logic [4:0] sh;
  logic [CNT_W-1:0] nxt;

  always_comb begin
    d = q;
    d.wdrst = 1'b0;
    access = PSEL_I & PENABLE_I;
    hit_mode = PADDR_I == MODE_ADDR;
    hit_rst = PADDR_I == RESTART_ADDR;
    hit_cause = PADDR_I == CAUSE_ADDR;
    fire = 1'b0;
    // stop code only honoured when the option allows it
    stopped = q.mode[CS_HI_BIT] & ~OPT_NO_STOP_I;
    use_xtal = q.mode[CS_LO_BIT] & ~q.mode[CS_HI_BIT] & ~OPT_NO_STOP_I;
    // clock gating of the count enable
    if (OPT_NO_STOP_I) begin
      tick = RING_TICK_I;
    end else if (stopped) begin
      tick = 1'b0;
    end else if (use_xtal) begin
      tick = XTAL_TICK_I & XTAL_RUN_I & ~HALT_I & ~STOP_I & ~OSC_SETTLE_I;
    end else begin
      tick = RING_TICK_I & ~HALT_I & ~STOP_I & ~(CPU_ON_XTAL_I & RING_OFF_I);
    end
    // overflow length selection
    sh = (use_xtal ? XTAL_BASE : RING_BASE) + {2'b00, q.mode[PERIOD_MSB:0]};
    nxt = q.cnt + CNT_W'(1);
    ovf = nxt[sh];
    if (tick) begin
      if (ovf) begin
        fire = 1'b1;
      end else begin
        d.cnt = nxt;
      end
    end
    eff_mode = 1'b0;
    eff_rst = 1'b0;
    good_rst = PSTRB_I[0] & (PWDATA_I[7:0] == RESTART_CODE);
    // bus phases
    case (q.phase)
      BUS_IDLE: begin
        if (access) begin
          d.pslverr = ~(hit_mode | hit_rst | hit_cause);
          if (hit_mode) begin
            d.prdata = {24'h000000, q.mode};
          end else if (hit_rst) begin
            d.prdata = {24'h000000, RESTART_READ};
          end else if (hit_cause) begin
            d.prdata = DATA_W'({q.cause, 4'h0});
          end else begin
            d.prdata = '0;
          end
          if (PWRITE_I & hit_mode) begin
            d.phase = BUS_WAIT;
            d.pready = 1'b0;
          end else begin
            d.phase = BUS_ACK;
            d.pready = 1'b1;
          end
        end
      end
      BUS_WAIT: begin
        d.phase = BUS_ACK;
        d.pready = 1'b1;
      end
      BUS_ACK: begin
        d.phase = BUS_IDLE;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        if (access & PWRITE_I) begin
          if (hit_mode) begin
            eff_mode = 1'b1;
            if (!q.locked) begin
              if (PSTRB_I[0]) begin
                if (OPT_NO_STOP_I) begin
                  d.mode = {MODE_FIXED_TOP, 2'b00, PWDATA_I[PERIOD_MSB:0]};
                end else begin
                  d.mode = PWDATA_I[7:0];
                end
                d.locked = 1'b1;
                d.cnt = '0;
              end
            end else if (!stopped) begin
              fire = 1'b1;
            end
          end else if (hit_rst) begin
            eff_rst = 1'b1;
            if (good_rst) begin
              d.cnt = '0;
            end else if (!stopped) begin
              fire = 1'b1;
            end
          end else if (hit_cause & PWDATA_I[CAUSE_BIT]) begin
            d.cause = 1'b0;
          end
        end
      end
      default: begin
        d.phase = BUS_IDLE;
        d.pready = 1'b0;
      end
    endcase
    // internal reset reinitialises the guard and sets the cause flag
    if (fire) begin
      d.wdrst = 1'b1;
      d.cause = 1'b1;
      d.mode = MODE_RESET;
      d.locked = 1'b0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= '{phase: BUS_IDLE, pready: 1'b0, pslverr: 1'b0, prdata: '0, mode: MODE_RESET,
             locked: 1'b0, cnt: '0, wdrst: 1'b0, cause: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign PREADY_O = q.pready;
  assign PRDATA_O = q.prdata;
  assign PSLVERR_O = q.pslverr;
  assign WD_RESET_O = q.wdrst;
  assign WD_CAUSE_O = q.cause;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  overflow_reset_a: assert property (tick && ovf |=> WD_RESET_O)
    else $error("overflow did not raise reset");
  cause_flag_a: assert property (WD_RESET_O |-> WD_CAUSE_O)
    else $error("reset without cause flag");
  mode_reinit_a: assert property (WD_RESET_O |-> q.mode == 8'h67 && !q.locked && q.cnt == '0)
    else $error("mode not reinitialised");
  period_len_a: assert property (tick && ovf |-> q.cnt == CNT_W'((22'h1 << sh) - 22'h1))
    else $error("overflow at wrong count");
  mode_wait_a: assert property (q.phase == BUS_IDLE && access && PWRITE_I && hit_mode
    |=> !PREADY_O ##1 PREADY_O)
    else $error("mode write lacked wait cycle");
  second_write_a: assert property (q.phase == BUS_ACK && eff_mode && q.locked && !stopped
    |=> WD_RESET_O)
    else $error("second mode write did not reset");
  bad_restart_a: assert property (q.phase == BUS_ACK && eff_rst && !good_rst && !stopped
    |=> WD_RESET_O)
    else $error("bad restart did not reset");
  good_restart_a: assert property (q.phase == BUS_ACK && eff_rst && good_rst
    |=> q.cnt == '0)
    else $error("restart did not clear counter");
  restart_read_a: assert property (q.phase == BUS_IDLE && access && !PWRITE_I && hit_rst
    |=> PRDATA_O[7:0] == 8'h9A)
    else $error("restart read not 9A");
  nostop_src_a: assert property (OPT_NO_STOP_I && $rose(q.locked) |-> q.mode[4:3] == 2'b00)
    else $error("source changed in fixed option");
  halt_hold_a: assert property (!OPT_NO_STOP_I && HALT_I && !WD_RESET_O && q.phase != BUS_ACK
    |=> q.cnt == $past(q.cnt) || WD_RESET_O)
    else $error("counter moved during halt");

  mode_clear_a: assert property (q.phase == BUS_ACK && eff_mode && !q.locked && PSTRB_I[0]
    |=> q.cnt == '0)
    else $error("mode write did not clear counter");

  mode_lock_a: assert property (q.phase == BUS_ACK && eff_mode && !q.locked && PSTRB_I[0]
    |=> q.locked || WD_RESET_O)
    else $error("mode write did not lock");

  locked_hold_a: assert property (q.locked
    |=> q.mode == $past(q.mode) || WD_RESET_O)
    else $error("locked mode changed");

  nostop_top_a: assert property (OPT_NO_STOP_I && q.locked
    |-> q.mode[7:5] == 3'b011)
    else $error("fixed top bits not kept");

  nostop_count_a: assert property (OPT_NO_STOP_I && RING_TICK_I && !ovf && q.phase != BUS_ACK
    |=> q.cnt == $past(nxt))
    else $error("fixed option counter halted");

  stop_hold_a: assert property (stopped && q.phase != BUS_ACK
    |=> q.cnt == $past(q.cnt))
    else $error("stopped counter moved");

  stop_quiet_a: assert property (stopped
    |=> !WD_RESET_O)
    else $error("stopped guard raised reset");

  xtal_gate_a: assert property (use_xtal && (!XTAL_RUN_I || HALT_I || STOP_I || OSC_SETTLE_I)
    && q.phase != BUS_ACK |=> q.cnt == $past(q.cnt))
    else $error("crystal count not paused");

  ring_gate_a: assert property (!OPT_NO_STOP_I && !stopped && !use_xtal && q.phase != BUS_ACK
    && (STOP_I || (CPU_ON_XTAL_I && RING_OFF_I)) |=> q.cnt == $past(q.cnt))
    else $error("oscillator count not paused");

  xtal_tick_a: assert property (use_xtal && tick
    |-> XTAL_TICK_I)
    else $error("crystal source counted without crystal tick");

  ring_tick_a: assert property (OPT_NO_STOP_I && tick
    |-> RING_TICK_I)
    else $error("fixed option counted without oscillator tick");

  reset_pulse_a: assert property (WD_RESET_O && q.phase != BUS_ACK
    |=> !WD_RESET_O)
    else $error("reset pulse too long");

  cause_hold_a: assert property (WD_CAUSE_O && !(q.phase == BUS_ACK && access && PWRITE_I && hit_cause)
    |=> WD_CAUSE_O)
    else $error("cause flag dropped");

  cause_clear_a: assert property (q.phase == BUS_ACK && access && PWRITE_I && hit_cause
    && PWDATA_I[CAUSE_BIT] && !fire |=> !WD_CAUSE_O)
    else $error("cause flag not cleared");

  mode_read_a: assert property (q.phase == BUS_IDLE && access && !PWRITE_I && hit_mode
    |=> PRDATA_O[7:0] == $past(q.mode))
    else $error("mode read wrong");

  unmapped_err_a: assert property (q.phase == BUS_IDLE && access && !(hit_mode || hit_rst || hit_cause)
    |=> PSLVERR_O && PREADY_O)
    else $error("unmapped access without error");

  ready_pulse_a: assert property (PREADY_O
    |=> !PREADY_O)
    else $error("ready longer than one cycle");

  fast_ack_a: assert property (q.phase == BUS_IDLE && access && !(PWRITE_I && hit_mode)
    |=> PREADY_O)
    else $error("plain access not answered");

  reinit_period_a: assert property (WD_RESET_O
    |-> q.mode[PERIOD_MSB:0] == 3'b111 && !use_xtal && !stopped)
    else $error("reinit not longest oscillator period");

  count_step_a: assert property (tick && !ovf && q.phase != BUS_ACK
    |=> q.cnt == $past(nxt))
    else $error("counter did not step");

  overflow_c: cover property (WD_RESET_O && !eff_mode);
  restart_c: cover property (q.phase == BUS_ACK && eff_rst && good_rst);
  mode_write_c: cover property ($rose(q.locked));
  xtal_count_c: cover property (use_xtal && tick);
  bad_restart_c: cover property (q.phase == BUS_ACK && eff_rst && !good_rst);

endmodule

// File: testbench/tb_loop_guard_timer.sv
`timescale 1ns/1ns
module tb_loop_guard_timer;
  import loop_guard_pkg::*;
  logic CLK_I = 0, RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, OPT_NO_STOP_I = 1;
  logic [ADDR_W-1:0] PADDR_I = '0;
  logic [DATA_W-1:0] PWDATA_I = '0, PRDATA_O, rd;
  logic [3:0] PSTRB_I = 4'hF;
  logic RING_TICK_I = 1, XTAL_TICK_I = 0, XTAL_RUN_I = 1, HALT_I = 0, STOP_I = 0;
  logic OSC_SETTLE_I = 0, CPU_ON_XTAL_I = 0, RING_OFF_I = 0;
  logic PREADY_O, PSLVERR_O, WD_RESET_O, WD_CAUSE_O, er;
  int mismatches = 0, num_checks = 0, resets = 0, n, r0, c;
  logic [7:0] v;
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) if (WD_RESET_O === 1'b1) resets <= resets + 1;
  loop_guard_timer dut_u (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PREADY_O(PREADY_O), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .OPT_NO_STOP_I(OPT_NO_STOP_I),
    .RING_TICK_I(RING_TICK_I), .XTAL_TICK_I(XTAL_TICK_I), .XTAL_RUN_I(XTAL_RUN_I), .HALT_I(HALT_I),
    .STOP_I(STOP_I), .OSC_SETTLE_I(OSC_SETTLE_I), .CPU_ON_XTAL_I(CPU_ON_XTAL_I),
    .RING_OFF_I(RING_OFF_I), .WD_RESET_O(WD_RESET_O), .WD_CAUSE_O(WD_CAUSE_O));
  function automatic logic [31:0] exp_mode(input logic opt, input logic [7:0] w);
    return opt ? {24'h0, 5'h0C, w[2:0]} : {24'h0, w};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    n = 0;
    @(posedge CLK_I);
    PSEL_I <= 1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= {24'h0, d}; PSTRB_I <= s;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    do begin @(negedge CLK_I); n++; end while (PREADY_O !== 1'b1 && n < 20);
    rd = PRDATA_O; er = PSLVERR_O;
    @(posedge CLK_I);
    PSEL_I <= 0; PENABLE_I <= 0;
    if (n >= 20) begin mismatches++; give_verdict(); end
  endtask
  task automatic do_reset(input logic opt);
    RST_I <= 1; OPT_NO_STOP_I <= opt;
    repeat (3) @(posedge CLK_I);
    RST_I <= 0;
  endtask
  task automatic wait_ovf(input int lo, input int hi);
    r0 = resets; n = 0;
    while (resets == r0 && n < hi) begin @(posedge CLK_I); n++; end
    chk("overflow_time", 1, n >= lo && n < hi);
    if (n >= hi) give_verdict();
  endtask
  task automatic quiet(input int cyc);
    r0 = resets;
    repeat (cyc) @(posedge CLK_I);
    chk("no_reset", r0, resets);
  endtask
  task automatic bad_write(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, input int k);
    r0 = resets;
    apb(1, a, d, s);
    repeat (3) @(posedge CLK_I);
    chk("reset_count", r0 + k, resets);
  endtask
  initial begin
    void'($urandom(32'h77FD16E6));
    do_reset(1);
    apb(0, MODE_ADDR, 0, 4'hF); chk("mode_init", 32'h67, rd);
    apb(0, RESTART_ADDR, 0, 4'hF); chk("restart_read", 32'h9A, rd);
    apb(0, 20'h00010, 0, 4'hF); chk("unmapped_err", 1, er);
    $display("test reset_values done");
    c = $urandom_range(2, 0);
    apb(1, MODE_ADDR, 8'hF8 | c, 4'hF); chk("mode_wait", 3, n);
    apb(0, MODE_ADDR, 0, 4'hF); chk("mode_masked", exp_mode(1, 8'hF8 | c), rd);
    wait_ovf((1 << (11 + c)) - 20, (1 << (11 + c)) + 5);
    repeat (2) @(posedge CLK_I);
    chk("cause_flag", 1, WD_CAUSE_O);
    apb(0, CAUSE_ADDR, 0, 4'hF); chk("cause_reg", 1, rd[4]);
    apb(1, CAUSE_ADDR, 8'h10, 4'hF);
    apb(0, CAUSE_ADDR, 0, 4'hF); chk("cause_clear", 0, rd[4]);
    apb(0, MODE_ADDR, 0, 4'hF); chk("mode_reinit", 32'h67, rd);
    $display("test fixed_source done");
    apb(1, MODE_ADDR, 8'h60, 4'hF);
    repeat (3) begin quiet(1500); apb(1, RESTART_ADDR, RESTART_CODE, 4'hF); end
    bad_write(MODE_ADDR, 8'h60, 4'hF, 1);
    v = $urandom;
    if (v == RESTART_CODE) v = v ^ 8'h01;
    bad_write(RESTART_ADDR, v, 4'hF, 1);
    bad_write(RESTART_ADDR, RESTART_CODE, 4'hE, 1);
    $display("test restart_rules done");
    do_reset(0);
    apb(1, MODE_ADDR, 8'h70, 4'hF);
    apb(0, MODE_ADDR, 0, 4'hF); chk("mode_stop", exp_mode(0, 8'h70), rd);
    quiet(3000);
    bad_write(RESTART_ADDR, v, 4'hF, 0);
    bad_write(MODE_ADDR, 8'h60, 4'hF, 0);
    $display("test stoppable done");
    do_reset(0);
    RING_TICK_I <= 0; XTAL_TICK_I <= 1;
    apb(1, MODE_ADDR, 8'h68, 4'hF);
    HALT_I <= 1;
    quiet(1000);
    HALT_I <= 0; STOP_I <= 1;
    quiet(500);
    STOP_I <= 0; OSC_SETTLE_I <= 1;
    quiet(500);
    OSC_SETTLE_I <= 0; XTAL_RUN_I <= 0;
    quiet(500);
    XTAL_RUN_I <= 1;
    wait_ovf(8192 - 20, 8192 + 10);
    RING_TICK_I <= 1; XTAL_TICK_I <= 0;
    apb(1, MODE_ADDR, 8'h60, 4'hF);
    HALT_I <= 1;
    quiet(3000);
    HALT_I <= 0; STOP_I <= 1;
    quiet(500);
    STOP_I <= 0; CPU_ON_XTAL_I <= 1; RING_OFF_I <= 1;
    quiet(1000);
    CPU_ON_XTAL_I <= 0; RING_OFF_I <= 0;
    wait_ovf(2048 - 20, 2048 + 10);
    $display("test clock_gating done");
    give_verdict();
  end
endmodule
